// ===== ext_irq_consts.vh
// constants and overview for the external interrupt pin unit
// Overview of operation
// - pin function enable low disables interrupt logic and frees the pin for port use
// - qualifying pin activity sets one request latch held until cleared
// - vector fetch makes an acknowledge pulse clearing the latch
// - writing 1 to the acknowledge bit clears the latch; it reads 0
// - any reset clears the request latch
// - falling edge only after reset; select bit adds low level sensing
// - mask bit 1 hides the request from priority logic; 0 enables
// - level mode keeps request active while pin is low
// - level mode clears only after acknowledge and pin high, either order
// - a falling edge after an acknowledge sets the latch again
// - reset clears the select bit, removing request even with pin low
// - edge mode acknowledge clears latch at once whatever the pin level
// - read-only pending flag shows request, independent of the mask
// - unit runs in wait and stop; unmasked request wakes the processor
// - with break clear enable clear, accesses in break leave status unchanged
// - pin internal pullup is enabled only while pin function enable is high
// - current pin level is offered to pin-level branch instructions
`ifndef EXT_IRQ_CONSTS_VH
`define EXT_IRQ_CONSTS_VH
// ==========================================
// register map and fields
`define STATUS_CONTROL_ADDR 8'h00
`define BIT_SENSE_LEVEL 0
`define BIT_REQUEST_MASK 1
`define BIT_ACK 2
`define BIT_PENDING 3
`define RESET_STATUS_CONTROL 8'h00
`endif

// ===== ext_irq_unit.v
// external interrupt pin unit: request latch, mask, mode select, register port
`include "ext_irq_consts.vh"
`default_nettype none
module ext_irq_unit #(
   parameter ADDR_W = 8
) (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // register port
   input wire [ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // configuration and system
   input wire pin_function_enable,
   input wire vector_fetch,
   input wire debug_break,
   input wire break_clear_enable,
   // pin, active low
   input wire irq_pin_n,
   output reg pin_pullup_en,
   output reg pin_level,
   output reg port_pin_release,
   // to priority logic and wakeup
   output reg irq_request,
   output reg wakeup,
   output reg irq_ack_pulse
);
   // ==========================================
   // pin synchroniser
   reg sync1_q, sync2_q, prev_q;
   // sync flops keep sampling through reset: a pin held low across reset must not look like a fresh edge
   always @(posedge mclk) begin
      sync1_q <= irq_pin_n;
      sync2_q <= sync1_q;
   end
   always @(posedge mclk) begin
      if (!rst_n)
         prev_q <= 1'b0;
      else
         prev_q <= sync2_q;
   end
   wire falling = pin_function_enable & prev_q & ~sync2_q;
   wire low_level = pin_function_enable & ~sync2_q;
   // ==========================================
   // control register and latch
   reg sense_level_q, mask_q, latch_q;
   wire hit = (reg_addr == `STATUS_CONTROL_ADDR);
   // software acknowledge clears status during break only when allowed
   wire clr_allowed = ~debug_break | break_clear_enable;
   wire sw_ack = reg_wr & hit & reg_wdata[`BIT_ACK] & clr_allowed;
   wire hw_ack = vector_fetch & pin_function_enable;
   wire ack = sw_ack | hw_ack;
   // disabled pin function hides a latched request at once
   wire req_now = pin_function_enable & (latch_q | (sense_level_q & low_level));
   always @(posedge mclk) begin
      if (!rst_n) begin
         sense_level_q <= 1'b0;
         mask_q <= 1'b0;
         latch_q <= 1'b0;
      end else begin
         if (reg_wr && hit) begin
            sense_level_q <= reg_wdata[`BIT_SENSE_LEVEL];
            mask_q <= reg_wdata[`BIT_REQUEST_MASK];
         end
         // new edge wins over a same-cycle acknowledge
         if (falling)
            latch_q <= 1'b1;
         else if (ack)
            latch_q <= 1'b0;
         else if (!pin_function_enable)
            latch_q <= 1'b0;
      end
   end
   // ==========================================
   // outputs
   always @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
         irq_request <= 1'b0;
         wakeup <= 1'b0;
         irq_ack_pulse <= 1'b0;
         pin_pullup_en <= 1'b0;
         pin_level <= 1'b1;
         port_pin_release <= 1'b1;
      end else begin
         reg_rdata <= 8'h00;
         if (reg_rd && hit) begin
            reg_rdata[`BIT_SENSE_LEVEL] <= sense_level_q;
            reg_rdata[`BIT_REQUEST_MASK] <= mask_q;
            reg_rdata[`BIT_PENDING] <= req_now;
         end
         irq_request <= req_now & ~mask_q;
         wakeup <= req_now & ~mask_q;
         irq_ack_pulse <= ack;
         pin_pullup_en <= pin_function_enable;
         pin_level <= sync2_q;
         port_pin_release <= ~pin_function_enable;
      end
   end
endmodule
`default_nettype wire

// ===== irq_source.sv
// behavioural source driving the active-low interrupt pin
`default_nettype none
module irq_source(
   input wire logic mclk,
   input wire logic low,
   output var logic irq_pin_n = 1'b1);
   timeunit 1ns; timeprecision 1ps;
   always @(posedge mclk) irq_pin_n <= !low;
endmodule
`default_nettype wire

// ===== ext_irq_chk.sv
// assertion checker for the external interrupt pin unit
`default_nettype none
module ext_irq_chk(
   // clock, reset and register read side
   input wire logic mclk, rst_n, reg_rd,
   input wire logic [7:0] reg_rdata,
   // configuration, fetch and pin
   input wire logic pin_function_enable, vector_fetch, irq_pin_n,
   // outputs
   input wire logic pin_pullup_en, pin_level, port_pin_release, irq_request, wakeup, irq_ack_pulse);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_wake_match: assert property (wakeup == irq_request) else $error("wake differs");
   a_pin_release: assert property (port_pin_release != pin_pullup_en) else $error("release");
   a_fetch_ack: assert property (vector_fetch && pin_function_enable |=> irq_ack_pulse) else $error("ack");
   a_ack_reads0: assert property (reg_rd |=> !reg_rdata[2] && reg_rdata[7:4] == 4'h0) else $error("rd");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("rdata");
   a_pin_sync: assert property ($stable(irq_pin_n) [*4] |-> pin_level == irq_pin_n) else $error("lvl");
   a_off_quiet: assert property (!pin_function_enable |=> !irq_request) else $error("off");
   a_reset_clear: assert property (disable iff (1'b0) !rst_n |=> !irq_request) else $error("rst");
endmodule
bind ext_irq_unit ext_irq_chk u_ext_irq_chk(.*);
`default_nettype wire

// ===== tb_ext_irq_unit.sv
// self-checking testbench for the external interrupt pin unit
`default_nettype none
`define CHK(a,b) begin tests_run++; if ((a)!==(b)) begin errors++; $display("ERROR %0t %h %h",$time,a,b); end end
module tb_ext_irq_unit;
   timeunit 1ns; timeprecision 1ps;
   logic mclk=0, rst_n=0, wr=0, rd=0, vf=0, brk=0, bce=0, en=1, low=0;
   logic [7:0] a=8'h00, d=8'h00;
   wire logic [7:0] q;
   wire logic pin, lvl, req;
   int errors=0, tests_run=0, seed=29, cyc=0;
   ext_irq_unit u_ext_irq_unit(.mclk(mclk), .rst_n(rst_n), .reg_addr(a), .reg_wdata(d), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(q), .pin_function_enable(en), .vector_fetch(vf), .debug_break(brk), .break_clear_enable(bce),
      .irq_pin_n(pin), .pin_pullup_en(), .pin_level(lvl), .port_pin_release(), .irq_request(req), .wakeup(),
      .irq_ack_pulse());
   irq_source u_irq_source(.mclk(mclk), .low(low), .irq_pin_n(pin));
   initial forever #12.5 mclk = ~mclk;
   task cy(int n); repeat (n) @(posedge mclk); endtask
   task wr8(logic [7:0] v); wr <= 1; d <= v; @(posedge mclk); wr <= 0; endtask
   task rd8(logic [7:0] e); rd <= 1; @(posedge mclk); rd <= 0; #1 `CHK(q, e) @(posedge mclk); endtask
   task results;
      $display("tests %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // cut a hang short well beyond the expected run
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 3000) begin errors++; results; end
   end
   initial begin
      cy(5); rst_n <= 1; cy(1);
      rd8(8'h00);
      a <= 8'h10; rd8(8'h00); a <= 8'h00;
      low <= 1; cy(6); #1 `CHK(req, 1'b1)
      rd8(8'h08);
      wr8(8'h04); cy(1); #1 `CHK(req, 1'b0)
      low <= 0; cy(4); low <= 1; cy(6); #1 `CHK(req, 1'b1)
      wr8(8'h02); cy(1); #1 `CHK(req, 1'b0)
      rd8(8'h0a);
      wr8(8'h01); cy(1); wr8(8'h05); cy(1); rd8(8'h09);
      wr8(8'h03); cy(1); #1 `CHK(req, 1'b0)
      low <= 0; cy(4); rd8(8'h03);
      wr8(8'h00); brk <= 1; low <= 1; cy(6); wr8(8'h04); cy(1); #1 `CHK(req, 1'b1)
      bce <= 1; wr8(8'h04); brk <= 0; cy(2); #1 `CHK(req, 1'b0)
      low <= 0; cy(4); low <= 1; cy(6); vf <= 1; cy(1); vf <= 0; cy(1); #1 `CHK(req, 1'b0)
      low <= 0; cy(4); low <= 1; cy(6); en <= 0; cy(2); #1 `CHK(req, 1'b0)
      en <= 1;
      repeat (8) begin low <= 1'($random(seed)); cy(5); #1 `CHK(lvl, !low) end
      low <= 1; wr8(8'h01); cy(6); rst_n <= 0; cy(2); rst_n <= 1; cy(6); #1 `CHK(req, 1'b0)
      $display("all tests done");
      results;
   end
endmodule
`default_nettype wire
